// >>> rtl/fdm_regs.svh
// fdm_regs.svh: address map, command codes, field positions and counts of the
// floppy mailbox block.
// assumes the host presents byte addresses in the disk control range on its
// side bus; included by bare name.
`ifndef FDM_REGS_SVH
`define FDM_REGS_SVH

// ----------------------------------------------------------------
// address map (host byte addresses)
// ----------------------------------------------------------------
`define FDM_RANGE_LO 24'hFCC001
`define FDM_RANGE_HI 24'hFCC7FF
`define FDM_CMD_ADDR 24'hFCC001
`define FDM_OPC_ADDR 24'hFCC003
`define FDM_DRV_ADDR 24'hFCC005
`define FDM_SIDE_ADDR 24'hFCC007
`define FDM_SECT_ADDR 24'hFCC009
`define FDM_TRK_ADDR 24'hFCC00B
`define FDM_SPD_ADDR 24'hFCC00D
`define FDM_FMT_ADDR 24'hFCC00F
`define FDM_ERR_ADDR 24'hFCC011
`define FDM_TAG_ADDR 24'hFCC013
`define FDM_CAUSE_ADDR 24'hFCC07F
`define FDM_SCR_LO 24'hFCC181
`define FDM_SCR_HI 24'hFCC1FF
`define FDM_BUF_LO 24'hFCC501
`define FDM_BUF_HI 24'hFCC7FF

// ----------------------------------------------------------------
// controller command codes
// ----------------------------------------------------------------
`define FDM_CMD_XFER 8'h81
`define FDM_CMD_UNUSED 8'h82
`define FDM_CMD_SEEK 8'h83
`define FDM_CMD_JSR 8'h84
`define FDM_CMD_CLR_STAT 8'h85
`define FDM_CMD_SET_MASK 8'h86
`define FDM_CMD_CLR_MASK 8'h87
`define FDM_CMD_WAIT_COLD 8'h88
`define FDM_CMD_LOOP 8'h89

// ----------------------------------------------------------------
// operand encodings
// ----------------------------------------------------------------
`define FDM_OPC_MAX 8'h08
`define FDM_DRV_UPPER 8'h80
`define FDM_SIDE_BIT 4
`define FDM_SECT_MAX 8'h16
`define FDM_TRK_MAX 8'h2C
`define FDM_ERR_NONE 8'h00
`define FDM_ERR_BADOP 8'h01
`define FDM_ERR_RANGE 8'h02

// ----------------------------------------------------------------
// cause byte bit positions
// ----------------------------------------------------------------
`define FDM_B_SUM1 7
`define FDM_B_DONE1 6
`define FDM_B_BTN1 5
`define FDM_B_DISK1 4
`define FDM_B_SUM2 3
`define FDM_B_DONE2 2
`define FDM_B_BTN2 1
`define FDM_B_DISK2 0

// ----------------------------------------------------------------
// timing and sizes
// ----------------------------------------------------------------
`define FDM_XFER_NS 2000
`define FDM_CLK_NS 10
`define FDM_RAM_WORDS 1024

`endif

// >>> rtl/fdm_pkg.sv
// fdm_pkg.sv: types shared by the floppy mailbox block.
// assumes fdm_regs.svh supplies all numbers.
package fdm_pkg;

  // host side request: one byte lane per access
  typedef struct packed {
    logic sel;
    logic wr;
    logic [23:0] addr;
    logic [7:0] wdata;
  } fdm_req_t;

  // answer to the host
  typedef struct packed {
    logic ack;
    logic berr;
    logic [7:0] rdata;
  } fdm_rsp_t;

  // command interpreter states
  typedef enum logic [2:0] {
    FDM_IDLE,
    FDM_XFER,
    FDM_SEEK,
    FDM_JSR,
    FDM_WAIT_COLD,
    FDM_LOOP
  } fdm_state_t;

endpackage

// >>> rtl/fdm_mailbox.sv
// fdm_mailbox.sv: shared battery backed mailbox RAM, command interpreter and
// interrupt cause byte of the floppy controller.
// assumes a host bus with one byte per access at odd addresses, drive
// sense pins from the drive mechanics, and a retained supply for the RAM.
`timescale 1ns/1ps
`include "fdm_regs.svh"

module fdm_mailbox #(
  parameter int XFER_CYCLES = (`FDM_XFER_NS + `FDM_CLK_NS - 1) / `FDM_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire fdm_pkg::fdm_req_t host_req,
  input wire logic host_irq_en,
  input wire logic disk1_in,
  input wire logic disk2_in,
  input wire logic button1_in,
  input wire logic button2_in,
  input wire logic cold_start,
  output fdm_pkg::fdm_rsp_t host_rsp,
  output logic host_irq,
  output logic [7:0] drive_sel,
  output logic side_lower,
  output logic [7:0] track_pos,
  output logic busy
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // range test used by every region decode
  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // controller RAM index of a host byte address: one byte per host word, so
  // the lane bit drops out and the index wraps every 2K bytes
  function automatic logic [9:0] ram_index(input logic [23:0] addr);
    ram_index = addr[10:1];
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s1_q; // first stage, read only by second
  logic [3:0] pin_s2_q; // clean copies
  logic [3:0] pin_s3_q; // previous value for edges

  // pins come from the drive mechanics, asynchronous to ref_clk; the third
  // stage only remembers the clean value so that edges are seen once.
  // resetting all stages low matches an empty drive with the button up, so
  // reset makes no false edge in that case
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
    end else begin
      pin_s1_q <= {button2_in, button1_in, disk2_in, disk1_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // clean levels and one-cycle edge pulses for the cause logic
  wire disk1 = pin_s2_q[0];
  wire disk2 = pin_s2_q[1];
  wire disk_chg = |(pin_s2_q[1:0] ^ pin_s3_q[1:0]); // insert or removal
  wire btn1_rise = pin_s2_q[2] & ~pin_s3_q[2];
  wire btn2_rise = pin_s2_q[3] & ~pin_s3_q[3];

  // ----------------------------------------------------------------
  // host access decode
  // ----------------------------------------------------------------
  // an access is taken on the edge at which sel is first seen high; a host
  // that keeps sel up gets one answer only. the enable level is checked
  // on that same edge, so a refused access never touches the RAM
  logic req_d1_q; // sel seen last cycle, one answer per new select

  // region and register decode of the held address

  wire [23:0] a = host_req.addr;
  wire in_range = in_rng(a, `FDM_RANGE_LO, `FDM_RANGE_HI);
  wire odd = a[0];
  wire new_req = host_req.sel & ~req_d1_q & in_range;
  wire bad_en = new_req & ~host_irq_en;
  wire go = new_req & host_irq_en & odd;
  wire is_cause = (a == `FDM_CAUSE_ADDR);
  wire is_err = (a == `FDM_ERR_ADDR);
  wire is_cmd = (a == `FDM_CMD_ADDR);
  wire [9:0] ram_idx = ram_index(a);
  wire [9:0] cmd_idx = ram_index(`FDM_CMD_ADDR);
  // writes to the read-only bytes are answered but dropped
  wire host_wr = go & host_req.wr & ~is_cause & ~is_err;

  // ----------------------------------------------------------------
  // shared RAM: reset clears only the handshake byte, so other contents survive a board reset
  // ----------------------------------------------------------------
  logic [7:0] ram_q [0:`FDM_RAM_WORDS-1];
  logic [7:0] ram_rd;
  logic clr_cmd; // interpreter clears the handshake byte
  logic [7:0] err_q; // result of last transfer

  // the interpreter's clear has its own write so that a host write elsewhere
  // in the same cycle cannot swallow it and restart a finished command;
  // a host write to the command byte itself still wins over the clear.
  // reset drops only the handshake byte: a retained loop or transfer code
  // must not restart on its own once reset is released
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ram_q[cmd_idx] <= 8'h00;
    end else begin
      if (host_wr) begin
        ram_q[ram_idx] <= host_req.wdata;
      end
      if (clr_cmd && !(host_wr && is_cmd)) begin
        ram_q[cmd_idx] <= 8'h00;
      end
    end
  end

  // command block fields as the interpreter sees them
  wire [7:0] cmd_byte = ram_q[cmd_idx];
  wire [7:0] opc = ram_q[ram_index(`FDM_OPC_ADDR)];
  wire [7:0] drv = ram_q[ram_index(`FDM_DRV_ADDR)];
  wire [7:0] side = ram_q[ram_index(`FDM_SIDE_ADDR)];
  wire [7:0] sect = ram_q[ram_index(`FDM_SECT_ADDR)];
  wire [7:0] trk = ram_q[ram_index(`FDM_TRK_ADDR)];

  // ----------------------------------------------------------------
  // cause byte
  // ----------------------------------------------------------------
  logic done1_q; // transfer complete, drive 1
  logic done2_q; // transfer complete, drive 2
  logic btn1_q; // eject button, drive 1
  logic btn2_q; // eject button, drive 2
  logic chg_q; // disk change event pending
  logic mask_q; // interrupt mask, set blocks the output
  logic fin1; // completion pulse, drive 1
  logic fin2; // completion pulse, drive 2
  logic clr_stat; // command 85H

  // presence bits follow the pins live; button and done bits are sticky
  // until the host issues the status clear command
  wire [7:0] cause = {
    (disk1 | btn1_q | done1_q),
    done1_q,
    btn1_q,
    disk1,
    (disk2 | btn2_q | done2_q),
    done2_q,
    btn2_q,
    disk2
  };

  // sticky flags: a new event in the clear cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done1_q <= 1'b0;
      done2_q <= 1'b0;
      btn1_q <= 1'b0;
      btn2_q <= 1'b0;
      chg_q <= 1'b0;
    end else begin
      done1_q <= fin1 | (done1_q & ~clr_stat);
      done2_q <= fin2 | (done2_q & ~clr_stat);
      btn1_q <= btn1_rise | (btn1_q & ~clr_stat);
      btn2_q <= btn2_rise | (btn2_q & ~clr_stat);
      chg_q <= disk_chg | (chg_q & ~clr_stat);
    end
  end

  // ----------------------------------------------------------------
  // command interpreter
  // ----------------------------------------------------------------
  // interpreter state and the operands latched at command start
  fdm_pkg::fdm_state_t st_q;
  fdm_pkg::fdm_state_t st_d;
  logic [15:0] cnt_q; // transfer duration counter
  logic drv_up_q; // drive latched at command start
  logic [7:0] drive_q;
  logic side_q;
  logic [7:0] trk_q;

  wire opc_ok = (opc <= `FDM_OPC_MAX);
  wire par_ok = (sect <= `FDM_SECT_MAX) && (trk <= `FDM_TRK_MAX);
  // end count is one short because the first transfer cycle counts zero
  wire cnt_end = (cnt_q == 16'(XFER_CYCLES - 1));
  wire idle = (st_q == fdm_pkg::FDM_IDLE);

  // the interpreter polls the handshake byte while idle, so a command is
  // seen on the cycle after the host writes it. a code that is not a
  // command is left in place and ignored
  // next state and one-cycle actions
  always_comb begin
    st_d = st_q;
    clr_cmd = 1'b0;
    clr_stat = 1'b0;
    fin1 = 1'b0;
    fin2 = 1'b0;
    case (st_q)
      fdm_pkg::FDM_IDLE: begin
        // only codes of the command table are acted on
        case (cmd_byte)
          `FDM_CMD_XFER: st_d = fdm_pkg::FDM_XFER;
          `FDM_CMD_SEEK: st_d = fdm_pkg::FDM_SEEK;
          `FDM_CMD_JSR: st_d = fdm_pkg::FDM_JSR;
          `FDM_CMD_CLR_STAT: begin
            clr_stat = 1'b1;
            clr_cmd = 1'b1;
          end
          `FDM_CMD_SET_MASK, `FDM_CMD_CLR_MASK, `FDM_CMD_UNUSED: begin
            clr_cmd = 1'b1;
          end
          `FDM_CMD_WAIT_COLD: st_d = fdm_pkg::FDM_WAIT_COLD;
          `FDM_CMD_LOOP: st_d = fdm_pkg::FDM_LOOP;
          default: st_d = fdm_pkg::FDM_IDLE; // not a command, ignore
        endcase
      end
      fdm_pkg::FDM_XFER: begin
        // the counter runs only here, so each transfer takes the same time
        if (cnt_end) begin
          st_d = fdm_pkg::FDM_IDLE;
          clr_cmd = 1'b1;
          fin1 = drv_up_q;
          fin2 = ~drv_up_q;
        end
      end
      fdm_pkg::FDM_SEEK, fdm_pkg::FDM_JSR: begin
        // the subroutine body lives in controller firmware; here it returns
        st_d = fdm_pkg::FDM_IDLE;
        clr_cmd = 1'b1;
      end
      fdm_pkg::FDM_WAIT_COLD: begin
        // held here until the cold start level is seen
        if (cold_start) begin
          st_d = fdm_pkg::FDM_IDLE;
          clr_cmd = 1'b1;
        end
      end
      fdm_pkg::FDM_LOOP: st_d = fdm_pkg::FDM_LOOP; // only reset leaves
      default: st_d = fdm_pkg::FDM_IDLE;
    endcase
  end

  // state, counter, mask
  // the mask only blocks the output; causes still collect while masked
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= fdm_pkg::FDM_IDLE;
      cnt_q <= 16'h0000;
      mask_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= (st_q == fdm_pkg::FDM_XFER) ? cnt_q + 16'h0001 : 16'h0000;
      if (idle && cmd_byte == `FDM_CMD_SET_MASK) begin
        mask_q <= 1'b1;
      end else if (idle && cmd_byte == `FDM_CMD_CLR_MASK) begin
        mask_q <= 1'b0;
      end
    end
  end

  // latch operands when a transfer or seek starts
  // a transfer with bad operands still runs for its full time; the host
  // learns of the problem from the error byte
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drv_up_q <= 1'b0;
      drive_q <= 8'h00;
      side_q <= 1'b0;
      trk_q <= 8'h00;
      err_q <= `FDM_ERR_NONE;
    end else if (idle && (cmd_byte == `FDM_CMD_XFER || cmd_byte == `FDM_CMD_SEEK)) begin
      drv_up_q <= (drv == `FDM_DRV_UPPER);
      drive_q <= drv;
      side_q <= side[`FDM_SIDE_BIT];
      trk_q <= trk;
      if (cmd_byte == `FDM_CMD_XFER) begin
        err_q <= !opc_ok ? `FDM_ERR_BADOP : (!par_ok ? `FDM_ERR_RANGE : `FDM_ERR_NONE);
      end
    end
  end

  // ----------------------------------------------------------------
  // host answer and outputs
  // ----------------------------------------------------------------
  // read multiplexer: the two read-only bytes shadow their RAM locations
  assign ram_rd = is_cause ? cause : (is_err ? err_q : ram_q[ram_idx]);

  // every output leaves a flip-flop, so the host sees a clean level one
  // cycle after the cause
  // one answer per access, one cycle after select; even lane reads zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_d1_q <= 1'b0;
      host_rsp <= '0;
      host_irq <= 1'b0;
      drive_sel <= 8'h00;
      side_lower <= 1'b0;
      track_pos <= 8'h00;
      busy <= 1'b0;
    end else begin
      req_d1_q <= host_req.sel;
      host_rsp.ack <= new_req & host_irq_en;
      host_rsp.berr <= bad_en;
      host_rsp.rdata <= (go & ~host_req.wr) ? ram_rd : 8'h00;
      host_irq <= ~mask_q & (chg_q | cause[`FDM_B_SUM1] & (done1_q | btn1_q)
                  | cause[`FDM_B_SUM2] & (done2_q | btn2_q));
      drive_sel <= drive_q;
      side_lower <= side_q;
      track_pos <= trk_q;
      busy <= ~idle;
    end
  end

endmodule

// >>> bench/fdm_mailbox_asserts.sv
// fdm_mailbox_asserts.sv: port checker of the floppy mailbox.
// assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
`include "fdm_regs.svh"
module fdm_mailbox_asserts #(
  parameter int XFER_CYCLES = 200
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire fdm_pkg::fdm_req_t host_req,
  input wire logic host_irq_en,
  input wire logic disk1_in,
  input wire logic disk2_in,
  input wire logic button1_in,
  input wire logic button2_in,
  input wire logic cold_start,
  input wire fdm_pkg::fdm_rsp_t host_rsp,
  input wire logic host_irq,
  input wire logic [7:0] drive_sel,
  input wire logic side_lower,
  input wire logic [7:0] track_pos,
  input wire logic busy
);
  // ----------------
  // port relations
  // ----------------
  localparam int XLO = XFER_CYCLES - 1; // four cycles of slack below the fall, which comes XFER_CYCLES + 3 after the select
  localparam int XHI = XFER_CYCLES + 8;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // address inside the disk range
  wire in_rng = host_req.addr >= `FDM_RANGE_LO && host_req.addr <= `FDM_RANGE_HI;
  // sector transfer command written to the command byte
  wire go81 = host_req.wr && host_req.addr == `FDM_CMD_ADDR && host_req.wdata == 8'h81;
  // answer to a read of the cause byte
  sequence cause_rd;
    host_rsp.ack && $past(host_req.addr) == `FDM_CAUSE_ADDR && !$past(host_req.wr);
  endsequence
  a_ack_taken: assert property ($rose(host_req.sel) && in_rng && host_irq_en
    |=> host_rsp.ack && !host_rsp.berr) else $error("access not answered");
  a_berr_no_en: assert property ($rose(host_req.sel) && in_rng && !host_irq_en
    |=> host_rsp.berr && !host_rsp.ack) else $error("disabled access not refused");
  a_out_silent: assert property ($rose(host_req.sel) && !in_rng
    |=> !host_rsp.ack && !host_rsp.berr) else $error("answer outside range");
  a_even_zero: assert property ($rose(host_req.sel) && !host_req.addr[0]
    |=> host_rsp.rdata == 8'h00) else $error("even address gave data");
  a_sum_bits: assert property (cause_rd |-> host_rsp.rdata[7] == |host_rsp.rdata[6:4]
    && host_rsp.rdata[3] == |host_rsp.rdata[2:0]) else $error("summary bit wrong");
  a_cause_live: assert property ((!rst && $stable(disk1_in) && $stable(disk2_in))[*6]
    ##0 cause_rd |-> host_rsp.rdata[4] == disk1_in && host_rsp.rdata[0] == disk2_in)
    else $error("presence bit wrong");
  a_xfer_busy: assert property ($rose(host_req.sel) && go81 && host_irq_en && !busy
    |-> ##[1:3] busy) else $error("transfer did not start");
  a_xfer_end: assert property ($rose(host_req.sel) && go81 && host_irq_en && !busy
    |-> ##[XLO:XHI] $fell(busy)) else $error("transfer length wrong");
  c_refused: cover property ($rose(host_req.sel) && !host_irq_en);
  c_done: cover property ($fell(busy));
  c_irq: cover property ($rose(host_irq));
endmodule
bind fdm_mailbox fdm_mailbox_asserts #(.XFER_CYCLES(XFER_CYCLES)) u_chk (.ref_clk, .rst,
  .host_req, .host_irq_en, .disk1_in, .disk2_in, .button1_in, .button2_in, .cold_start,
  .host_rsp, .host_irq, .drive_sel, .side_lower, .track_pos, .busy);

// >>> bench/fdm_host_model.sv
// fdm_host_model.sv: main cpu side of the mailbox, one byte per access.
// assumes an answer within four clocks, or none outside the range.
`timescale 1ns/1ps
module fdm_host_model (
  input wire logic ref_clk,
  output fdm_pkg::fdm_req_t host_req,
  input wire fdm_pkg::fdm_rsp_t host_rsp
);
  // ----------------
  // bus cycles
  // ----------------
  initial host_req = '0;
  // raised on a falling edge, held through the edge after the answer is
  // seen; released address and data lines show the inverse so a stale value never passes
  task automatic xfer(input logic w, input logic [23:0] a, input logic [7:0] d,
                      output logic [7:0] r, output logic [1:0] f);
    int i;
    @(negedge ref_clk);
    host_req = '{sel: 1'b1, wr: w, addr: a, wdata: d};
    f = 2'h0;
    r = 8'h00;
    for (i = 0; i < 4 && f == 2'h0; i++) begin
      @(negedge ref_clk);
      f = {host_rsp.ack, host_rsp.berr};
      r = host_rsp.rdata;
    end
    @(negedge ref_clk);
    host_req = '{sel: 1'b0, wr: w, addr: ~a, wdata: ~d};
  endtask
endmodule

// >>> bench/tb_top.sv
// tb_top.sv: self-checking bench of the floppy mailbox.
// assumes the host model and a transfer count cut to four clocks.
`timescale 1ns/1ps
`include "fdm_regs.svh"
module tb_top;
  // ----------------
  // bench and design
  // ----------------
  localparam logic [23:0] CMD = `FDM_CMD_ADDR;
  localparam logic [23:0] CAU = `FDM_CAUSE_ADDR;
  localparam logic [23:0] SCR = `FDM_SCR_LO;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1; // host enable, high for access
  logic d1 = 1'b0;
  logic d2 = 1'b0;
  logic b1 = 1'b0;
  logic b2 = 1'b0;
  logic cs = 1'b0; // cold start release
  fdm_pkg::fdm_req_t req;
  fdm_pkg::fdm_rsp_t rsp;
  logic irq, sl, bsy;
  logic [7:0] ds, tp;
  int n_errors = 0;
  int check_count = 0;
  always #5 ref_clk = ~ref_clk;
  fdm_mailbox #(.XFER_CYCLES(4)) dut (.ref_clk(ref_clk), .rst(rst), .host_req(req),
    .host_irq_en(en), .disk1_in(d1), .disk2_in(d2), .button1_in(b1), .button2_in(b2),
    .cold_start(cs), .host_rsp(rsp), .host_irq(irq), .drive_sel(ds), .side_lower(sl),
    .track_pos(tp), .busy(bsy));
  fdm_host_model h (.ref_clk(ref_clk), .host_req(req), .host_rsp(rsp));
  function automatic logic [7:0] z(input logic v);
    return {7'h00, v};
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic [1:0] f;
    h.xfer(1'b1, a, d, r, f);
    chk("write answer", 8'h02, {6'h00, f});
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    logic [7:0] r;
    logic [1:0] f;
    h.xfer(1'b0, a, 8'h00, r, f);
    chk($sformatf("read %h", a), e, r);
  endtask
  // bounded wait for the interpreter to go idle
  task automatic wait_idle();
    int i;
    ticks(3);
    for (i = 0; i < 100 && bsy !== 1'b0; i++) ticks(1);
    if (i == 100) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_map();
    logic [7:0] r;
    logic [1:0] f;
    wr(SCR, 8'h5A);
    wr(`FDM_BUF_HI, 8'hA5);
    rd(SCR, 8'h5A);
    rd(`FDM_BUF_HI, 8'hA5);
    rd(SCR - 24'h1, 8'h00);
    h.xfer(1'b0, 24'hFCC801, 8'h00, r, f);
    chk("outside answer", 8'h00, {6'h00, f});
    en = 1'b0;
    h.xfer(1'b1, SCR, 8'h33, r, f);
    chk("disabled answer", 8'h01, {6'h00, f});
    en = 1'b1;
    rd(SCR, 8'h5A);
  endtask
  // one transfer per opcode, drives and boundary operands alternating
  task automatic t_xfer(input int i);
    logic [7:0] drv;
    logic [7:0] sd;
    logic [7:0] tk;
    drv = i[0] ? `FDM_DRV_UPPER : 8'h00;
    sd = i[1] ? 8'h1F : 8'h0E; // low nibble must not matter
    tk = i[2] ? `FDM_TRK_MAX : 8'h00;
    wr(`FDM_OPC_ADDR, i[7:0]);
    wr(`FDM_DRV_ADDR, drv);
    wr(`FDM_SIDE_ADDR, sd);
    wr(`FDM_SECT_ADDR, i[0] ? `FDM_SECT_MAX : 8'h00);
    wr(`FDM_TRK_ADDR, tk);
    wr(CMD, `FDM_CMD_XFER);
    wait_idle();
    chk("drive_sel", drv, ds);
    chk("side_lower", z(sd[4]), z(sl));
    chk("track_pos", tk, tp);
    rd(CMD, 8'h00);
    rd(`FDM_ERR_ADDR, `FDM_ERR_NONE);
    rd(CAU, i[0] ? 8'hC0 : 8'h0C);
    chk("irq done", 8'h01, z(irq));
    wr(CMD, `FDM_CMD_CLR_STAT);
    wait_idle();
    rd(CAU, 8'h00);
    chk("irq cleared", 8'h00, z(irq));
  endtask
  task automatic t_events();
    wr(CMD, `FDM_CMD_SET_MASK);
    ticks(4);
    d1 = 1'b1;
    ticks(8);
    chk("irq masked", 8'h00, z(irq));
    rd(CAU, 8'h90);
    wr(CMD, `FDM_CMD_CLR_MASK);
    ticks(4);
    chk("irq insert", 8'h01, z(irq));
    wr(CMD, `FDM_CMD_CLR_STAT);
    d2 = 1'b1;
    b1 = 1'b1;
    ticks(8);
    rd(CAU, 8'hB9);
    b2 = 1'b1;
    ticks(8);
    rd(CAU, 8'hBB);
    wr(CMD, `FDM_CMD_CLR_STAT);
    {d1, d2, b1, b2} = 4'h0;
    ticks(8);
    chk("irq removal", 8'h01, z(irq));
    wr(CMD, `FDM_CMD_CLR_STAT);
    ticks(4);
    rd(CAU, 8'h00);
  endtask
  task automatic t_misc();
    for (logic [7:0] c = 8'h82; c != 8'h85; c++) begin
      wr(CMD, c);
      ticks(3);
      rd(CMD, 8'h00);
    end
    wr(`FDM_ERR_ADDR, 8'hFF);
    rd(`FDM_ERR_ADDR, `FDM_ERR_NONE);
    wr(CAU, 8'hFF);
    rd(CAU, 8'h00);
    wr(CMD, `FDM_CMD_WAIT_COLD);
    ticks(4);
    chk("busy waiting", 8'h01, z(bsy));
    rd(CMD, `FDM_CMD_WAIT_COLD);
    cs = 1'b1;
    ticks(1);
    cs = 1'b0;
    wait_idle();
    rd(CMD, 8'h00);
    wr(CMD, `FDM_CMD_LOOP);
    ticks(20);
    chk("busy looping", 8'h01, z(bsy));
    rst = 1'b1;
    ticks(2);
    rst = 1'b0;
    chk("busy after reset", 8'h00, z(bsy));
    ticks(4);
    chk("busy stays idle", 8'h00, z(bsy));
    rd(CMD, 8'h00);
    rd(SCR, 8'h5A);
  endtask
  // seek operands, then the error byte for a bad opcode and a bad track
  task automatic t_seek_err();
    wr(`FDM_TRK_ADDR, 8'h15);
    wr(`FDM_SIDE_ADDR, 8'h13);
    wr(`FDM_DRV_ADDR, `FDM_DRV_UPPER);
    wr(CMD, `FDM_CMD_SEEK);
    wait_idle();
    chk("seek track", 8'h15, tp);
    chk("seek side", 8'h01, z(sl));
    rd(CMD, 8'h00);
    wr(`FDM_OPC_ADDR, 8'h09);
    wr(CMD, `FDM_CMD_XFER);
    wait_idle();
    rd(`FDM_ERR_ADDR, `FDM_ERR_BADOP);
    wr(`FDM_OPC_ADDR, 8'h00);
    wr(`FDM_TRK_ADDR, 8'h2D);
    wr(CMD, `FDM_CMD_XFER);
    wait_idle();
    rd(`FDM_ERR_ADDR, `FDM_ERR_RANGE);
    rd(CAU, 8'hC0);
  endtask
  initial begin
    ticks(4);
    rst = 1'b0;
    t_map();
    for (int i = 0; i < 9; i++) t_xfer(i);
    t_events();
    t_misc();
    t_seek_err();
    give_verdict();
  end
endmodule
